// [inc/flsup_pkg.sv]
// constants and carrier types for the fault and line supervisor
// assumes a single 50 MHz clock and digital comparator flags from outside
package flsup_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned RESTART_MS = 1000;
	localparam int unsigned ZC_IDLE_MS = 700;
	localparam int unsigned DISCH_MS = 350;
	localparam int unsigned FIRST_TEST_MS = 12;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RESTART_CYC = RESTART_MS * CYC_PER_MS;
	localparam int unsigned ZC_IDLE_CYC = ZC_IDLE_MS * CYC_PER_MS;
	localparam int unsigned DISCH_CYC = DISCH_MS * CYC_PER_MS;
	localparam int unsigned FIRST_TEST_CYC = FIRST_TEST_MS * CYC_PER_MS;

	localparam int unsigned CNT_W = 32;
	localparam logic [2:0] BIAS_WINDING_OVERVOLT_GUARD_CYCLES = 3'h5;
	localparam logic [2:0] ZC_MISS_LIMIT = 3'h4;
	localparam int unsigned STEP_W = 3;
	localparam int unsigned MISS_W = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum {
		FS_STARTUP,
		FS_CHARGE,
		FS_FRONT_WAIT,
		FS_RUN,
		FS_FAULT
	} flsup_seq_t;

	typedef enum {
		ZS_IDLE,
		ZS_TEST,
		ZS_DISCH
	} flsup_zc_t;

	// analogue comparator flags, all asynchronous to clk_i
	typedef struct packed {
		logic bias_winding_overvolt_guard;
		logic input_undervolt_guard;
		logic input_overvolt_guard;
		logic bootstrap_uvlo;
		logic regulated_driver_supply_uvlo;
		logic over_temp;
		logic supply_above_short_detect_level;
		logic supply_above_start_level;
		logic front_stage_ready;
		logic zero_cross;
	} flsup_sense_t;

	// drive enables towards gate drivers and the high-voltage switch
	typedef struct packed {
		logic switching_en;
		logic high_gate_en;
		logic low_gate_en;
		logic regulated_driver_supply_en;
		logic hv_charge_small;
		logic hv_charge_large;
		logic hv_test_en;
		logic [STEP_W-1:0] hv_test_step;
		logic line_cap_discharge_current_en;
		logic fault;
		logic ac_disconnect;
	} flsup_drive_t;

endpackage

// [rtl/flsup_timer.sv]
// down counter that reports expiry; shared by restart and line timers
// assumes load and count come from logic on the same clock
`timescale 1ns/1ps
module flsup_timer (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic load_i,
	input wire logic [flsup_pkg::CNT_W-1:0] value_i,
	input wire logic run_i,
	output logic done_o
);
	import flsup_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic done;
	} flsup_tmr_state_t;

	flsup_tmr_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (load_i) begin
			s_d.cnt = value_i;
			s_d.done = 1'b0;
		end else if (run_i && !s_q.done) begin
			if (s_q.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.done;
endmodule

// [rtl/flsup_top.sv]
// fault and line supervisor: protection sequencing, self-start and
// line disconnect detection with timed capacitor discharge
// assumes comparator flags are asynchronous levels, switch_cycle_i a
// one-clock pulse from the switching core
`timescale 1ns/1ps

// Functional notes
// RULE_01 - bias overvoltage five cycles: fault, 1s restart
// RULE_02 - line undervoltage: halt, fault, 1s restart
// RULE_03 - line overvoltage: fault, restart once cleared
// RULE_04 - bootstrap low: high gate off only
// RULE_05 - driver supply low: both gates off, fault
// RULE_06 - over-temperature: fault, restart once cleared
// RULE_07 - small charge below short level, else large
// RULE_08 - above start level: charge off, supply on
// RULE_09 - switching waits for front stage ready
// RULE_10 - staircase test every 700 ms after idle
// RULE_11 - four misses at top step: discharge
// RULE_12 - any crossing stops test, back to idle
// RULE_13 - discharge current stays on 350 ms
// RULE_14 - first test 12 ms after self-start
// RULE_15 - self-start owns switch; test 12 ms after
// RULE_16 - crossing monitor runs in every mode
// RULE_17 - discharge: switch on plus sink enabled; the code enables only the sink
// RULE_18 - build option removes discharge entirely
// RULE_19 - step count and length are parameters
// RULE_20 - one fault latch, one restart timer
module flsup_top #(
	parameter int unsigned RESTART_CYCLES = flsup_pkg::RESTART_CYC,
	parameter int unsigned IDLE_CYCLES = flsup_pkg::ZC_IDLE_CYC,
	parameter int unsigned DISCH_CYCLES = flsup_pkg::DISCH_CYC,
	parameter int unsigned FIRST_TEST_CYCLES = flsup_pkg::FIRST_TEST_CYC,
	parameter int unsigned STEP_CYCLES = 500000,
	parameter int unsigned NUM_STEPS = 4,
	parameter bit HAS_LINE_OVP = 1'b1,
	parameter bit HAS_DISCHARGE = 1'b1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire flsup_pkg::flsup_sense_t sense_i,
	input wire logic switch_cycle_i,
	output flsup_pkg::flsup_drive_t drive_o
);
	import flsup_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		flsup_sense_t s1;
		flsup_sense_t s2;
		flsup_seq_t seq;
		flsup_zc_t zc;
		logic fault_latch;
		logic ovp_hold;
		logic otp_hold;
		logic [2:0] bw_cnt;
		logic [MISS_W-1:0] miss_cnt;
		logic [STEP_W-1:0] step;
		logic [CNT_W-1:0] step_cnt;
		logic zc_prev;
		logic arm_first;
		flsup_drive_t out;
	} flsup_state_t;

	flsup_state_t s_q, s_d;

	logic rst_load, rst_done;
	logic zc_load, zc_done;
	logic [CNT_W-1:0] zc_value;

	// restart timer shared by every fault source
	flsup_timer u_restart (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.load_i(rst_load),
		.value_i(CNT_W'(RESTART_CYCLES)),
		.run_i(s_q.seq == FS_FAULT),
		.done_o(rst_done)
	);

	// line timer: idle wait, first-test delay or discharge length
	flsup_timer u_line (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.load_i(zc_load),
		.value_i(zc_value),
		.run_i(1'b1),
		.done_o(zc_done)
	);

	logic bw_hi, uv, ov, rv_low, ot, zc_edge, any_fault;
	logic top_step, step_end, hv_busy;

	always_comb begin
		s_d = s_q;
		rst_load = 1'b0;
		zc_load = 1'b0;
		zc_value = CNT_W'(IDLE_CYCLES);

		s_d.s1 = sense_i;
		s_d.s2 = s_q.s1;

		bw_hi = s_q.s2.bias_winding_overvolt_guard;
		uv = s_q.s2.input_undervolt_guard;
		ov = HAS_LINE_OVP && s_q.s2.input_overvolt_guard;
		rv_low = s_q.s2.regulated_driver_supply_uvlo;
		ot = s_q.s2.over_temp;
		// both half-cycle crossings show as rising edges of the flag
		zc_edge = s_q.s2.zero_cross && !s_q.zc_prev;
		s_d.zc_prev = s_q.s2.zero_cross;

		// --------------------------------------------------------
		// protection
		// --------------------------------------------------------
		if (!bw_hi || s_q.seq != FS_RUN) begin
			s_d.bw_cnt = '0;
		end else if (switch_cycle_i && s_q.bw_cnt != BIAS_WINDING_OVERVOLT_GUARD_CYCLES) begin
			s_d.bw_cnt = s_q.bw_cnt + 3'h1; // see RULE_01
		end

		any_fault = (s_q.bw_cnt == BIAS_WINDING_OVERVOLT_GUARD_CYCLES) || uv || ov || rv_low || ot;

		s_d.ovp_hold = s_q.ovp_hold | ov;
		s_d.otp_hold = s_q.otp_hold | ot;

		// --------------------------------------------------------
		// supply sequencer
		// --------------------------------------------------------
		case (s_q.seq)
			FS_STARTUP: begin
				s_d.fault_latch = 1'b0; // see RULE_20
				s_d.ovp_hold = ov;
				s_d.otp_hold = ot;
				s_d.seq = FS_CHARGE;
			end
			FS_CHARGE: begin
				if (s_q.s2.supply_above_start_level) begin
					s_d.seq = FS_FRONT_WAIT; // see RULE_08
				end
			end
			FS_FRONT_WAIT: begin
				if (any_fault && !s_q.fault_latch) begin
					s_d.seq = FS_FAULT;
					rst_load = 1'b1;
				end else if (s_q.s2.front_stage_ready) begin
					s_d.seq = FS_RUN; // see RULE_09
				end
			end
			FS_RUN: begin
				if (any_fault) begin
					s_d.seq = FS_FAULT; // see RULE_01 RULE_02 RULE_05
					rst_load = 1'b1;
				end
			end
			FS_FAULT: begin
				s_d.fault_latch = 1'b1; // see RULE_20
				// ovp and otp wait for their level to clear
				if (rst_done && !ov && !ot) begin
					s_d.seq = FS_STARTUP; // see RULE_03 RULE_06
				end
			end
			default: begin
				s_d.seq = FS_STARTUP;
			end
		endcase

		// --------------------------------------------------------
		// line detector; tests in every sequencer state except FS_STARTUP and FS_CHARGE
		// --------------------------------------------------------
		// startup hands straight to charge, so it owns the switch too
		hv_busy = (s_q.seq == FS_STARTUP) ||
			(s_q.seq == FS_CHARGE); // see RULE_15
		top_step = (s_q.step == STEP_W'(NUM_STEPS - 1)); // see RULE_19
		step_end = (s_q.step_cnt == '0);

		// self-start just finished: first test after short delay
		if (s_q.seq == FS_CHARGE && s_d.seq == FS_FRONT_WAIT) begin
			s_d.arm_first = 1'b1;
			zc_load = 1'b1;
			zc_value = CNT_W'(FIRST_TEST_CYCLES); // see RULE_14 RULE_15
		end

		case (s_q.zc)
			ZS_IDLE: begin
				if (hv_busy) begin
					s_d.zc = ZS_IDLE;
				end else if (zc_done && !zc_load) begin
					s_d.zc = ZS_TEST; // see RULE_10
					s_d.arm_first = 1'b0;
					s_d.step = '0;
					s_d.miss_cnt = '0;
					s_d.step_cnt = CNT_W'(STEP_CYCLES - 1);
				end
			end
			ZS_TEST: begin
				s_d.step_cnt = s_q.step_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
				if (hv_busy || zc_edge) begin
					s_d.zc = ZS_IDLE; // see RULE_12 RULE_16
					if (!zc_load) begin
						zc_load = 1'b1;
						zc_value = CNT_W'(IDLE_CYCLES);
					end
				end else if (step_end) begin
					s_d.step_cnt = CNT_W'(STEP_CYCLES - 1);
					if (!top_step) begin
						s_d.step = s_q.step + STEP_W'(1);
					end else if (s_q.miss_cnt == ZC_MISS_LIMIT - 3'h1) begin
						// each top-step window is one expected crossing
						s_d.out.ac_disconnect = 1'b1; // see RULE_11
						zc_load = 1'b1;
						if (HAS_DISCHARGE) begin
							s_d.zc = ZS_DISCH;
							// exit costs one clock after expiry
							zc_value = CNT_W'(DISCH_CYCLES - 1); // see RULE_13
						end else begin
							s_d.zc = ZS_IDLE; // see RULE_18
							zc_value = CNT_W'(IDLE_CYCLES);
						end
					end else begin
						s_d.miss_cnt = s_q.miss_cnt + MISS_W'(1);
					end
				end
			end
			ZS_DISCH: begin
				if (zc_done && !zc_load) begin
					s_d.zc = ZS_IDLE;
					zc_load = 1'b1;
					zc_value = CNT_W'(IDLE_CYCLES);
				end
			end
			default: begin
				s_d.zc = ZS_IDLE;
			end
		endcase
		if (zc_edge) begin
			s_d.out.ac_disconnect = 1'b0;
		end

		// --------------------------------------------------------
		// outputs, from next state so every output is a flop
		// --------------------------------------------------------
		s_d.out.switching_en = (s_d.seq == FS_RUN);
		s_d.out.low_gate_en = (s_d.seq == FS_RUN) && !rv_low; // see RULE_05
		s_d.out.high_gate_en = (s_d.seq == FS_RUN) && !rv_low &&
			!s_q.s2.bootstrap_uvlo; // see RULE_04
		s_d.out.regulated_driver_supply_en = (s_d.seq == FS_FRONT_WAIT) ||
			(s_d.seq == FS_RUN); // see RULE_08
		s_d.out.hv_charge_small = (s_d.seq == FS_CHARGE) &&
			!s_q.s2.supply_above_short_detect_level; // see RULE_07
		s_d.out.hv_charge_large = (s_d.seq == FS_CHARGE) &&
			s_q.s2.supply_above_short_detect_level; // see RULE_07
		s_d.out.hv_test_en = (s_d.zc == ZS_TEST);
		s_d.out.hv_test_step = (s_d.zc == ZS_TEST) ? s_d.step : '0;
		s_d.out.line_cap_discharge_current_en = HAS_DISCHARGE &&
			(s_d.zc == ZS_DISCH); // see RULE_17 RULE_18
		s_d.out.fault = (s_d.seq == FS_FAULT);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign drive_o = s_q.out;
endmodule

// [dv/flsup_monitor.sv]
// checker on the supervisor top ports
// assumes it is bound into every flsup_top instance
`timescale 1ns/1ps
module flsup_monitor #(
	parameter int unsigned DISCH_CYCLES = 150
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire flsup_pkg::flsup_sense_t sense_i,
	input wire logic switch_cycle_i,
	input wire flsup_pkg::flsup_drive_t drive_o
);
	import flsup_pkg::*;
	logic [31:0] dcnt_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			dcnt_q <= '0;
		else if (drive_o.line_cap_discharge_current_en)
			dcnt_q <= dcnt_q + 32'h1;
		else
			dcnt_q <= '0;
	end
	// three samples cover the two-flop synchroniser
	sequence boot_low_s;
		sense_i.bootstrap_uvlo [*3];
	endsequence
	sequence drv_low_s;
		sense_i.regulated_driver_supply_uvlo [*3];
	endsequence
	a_boot_gate_off:
		assert property (boot_low_s |=> !drive_o.high_gate_en)
		else $error("high gate on with bootstrap low");
	a_drv_gates_off:
		assert property (drv_low_s |=> !drive_o.high_gate_en &&
			!drive_o.low_gate_en) else $error("gates on with supply low");
	a_fault_stops_all:
		assert property (drive_o.fault |-> !drive_o.switching_en &&
			!drive_o.high_gate_en) else $error("switching in fault");
	a_charge_no_supply:
		assert property (drive_o.hv_charge_small || drive_o.hv_charge_large
			|-> !drive_o.regulated_driver_supply_en)
		else $error("charge and supply together");
	a_test_no_charge:
		assert property (drive_o.hv_test_en |-> !drive_o.hv_charge_small &&
			!drive_o.hv_charge_large) else $error("test during charge");
	a_run_front_ready:
		assert property ($rose(drive_o.switching_en) |->
			$past(sense_i.front_stage_ready, 3)) else $error("early run");
	a_zc_stops_test:
		assert property (drive_o.hv_test_en && $rose(sense_i.zero_cross)
			|-> ##[1:5] !drive_o.hv_test_en) else $error("test not stopped");
	a_disch_flagged:
		assert property ($rose(drive_o.line_cap_discharge_current_en) |->
			drive_o.ac_disconnect) else $error("discharge without flag");
	a_disch_length:
		assert property ($fell(drive_o.line_cap_discharge_current_en) |->
			dcnt_q == DISCH_CYCLES) else $error("discharge length wrong");
endmodule
bind flsup_top flsup_monitor #(.DISCH_CYCLES(DISCH_CYCLES)) u_mon (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.sense_i(sense_i),
	.switch_cycle_i(switch_cycle_i),
	.drive_o(drive_o)
);

// [dv/flsup_partner.sv]
// supply capacitor, front stage, line and switching core model
// assumes drive_i comes from the supervisor on the same clock
`timescale 1ns/1ps
module flsup_partner (
	input wire logic clk_i,
	input wire flsup_pkg::flsup_drive_t drive_i,
	input wire logic line_on_i,
	output logic short_o,
	output logic start_o,
	output logic ready_o,
	output logic zc_o,
	output logic cyc_o
);
	import flsup_pkg::*;
	int vcc = 0;
	int rdy = 0;
	int ph = 0;
	// capacitor never drains: restarts find it charged
	always @(posedge clk_i) begin
		vcc <= vcc + (drive_i.hv_charge_large ? 4 :
			drive_i.hv_charge_small ? 1 : 0);
		rdy <= drive_i.regulated_driver_supply_en ? rdy + 1 : 0;
		ph <= ph + 1;
	end
	assign short_o = vcc >= 20;
	assign start_o = vcc >= 100;
	assign ready_o = rdy >= 30;
	// a crossing every 16 cycles while the line is present
	assign zc_o = line_on_i && ph[3];
	assign cyc_o = drive_i.switching_en && (ph % 4 == 0);
endmodule

// [dv/flsup_top_bench.sv]
// self-checking bench for the fault and line supervisor
// assumes shortened counts handed through the top parameters
`timescale 1ns/1ps
module flsup_top_bench;
	import flsup_pkg::*;
	localparam int SW = 12, RDS = 9, TST = 6, DIS = 2, FLT = 1, ACD = 0;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic line_on = 1'b1;
	logic [5:0] flt = 6'h00;
	logic sh, st, rd, zc, cyc;
	flsup_sense_t sense;
	flsup_drive_t drv;
	int n_fail = 0;
	int cmp_count = 0;
	int fl[5] = '{4, 3, 1, 0, 5};
	assign sense = {flt, sh, st, rd, zc};
	flsup_top #(.RESTART_CYCLES(200), .IDLE_CYCLES(300),
		.DISCH_CYCLES(150), .FIRST_TEST_CYCLES(20),
		.STEP_CYCLES(10)) DUT (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.sense_i(sense),
		.switch_cycle_i(cyc),
		.drive_o(drv)
	);
	flsup_partner u_far (
		.clk_i(clk_i),
		.drive_i(drv),
		.line_on_i(line_on),
		.short_o(sh),
		.start_o(st),
		.ready_o(rd),
		.zc_o(zc),
		.cyc_o(cyc)
	);
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// ----
	// helpers
	// ----
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s exp %0h got %0h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic wait_bit(input int b, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && drv[b] !== v; i++)
			tick(1);
		if (i == lim) begin
			n_fail++;
			$display("unexpected timeout on drive bit %0d", b);
			end_of_test();
		end
	endtask
	// ----
	// scenarios
	// ----
	task automatic run_start();
		int n;
		wait_bit(RDS, 1'b1, 400);
		for (n = 0; n < 40 && drv.hv_test_en !== 1'b1; n++)
			tick(1);
		chk("first test delay", 1, n >= 18 && n <= 23);
		wait_bit(TST, 1'b0, 60);
		chk("disconnect", 0, drv.ac_disconnect);
		wait_bit(SW, 1'b1, 400);
		chk("charge", 0, {drv.hv_charge_small, drv.hv_charge_large});
	endtask
	task automatic run_boot();
		flt[2] = 1'b1;
		tick(6);
		chk("high gate", 0, drv.high_gate_en);
		chk("boot fault", 0, drv.fault);
		chk("boot run", 1, drv.switching_en);
		flt[2] = 1'b0;
		tick(6);
	endtask
	task automatic run_bias_short();
		// at most four switching pulses fit in this window
		flt[5] = 1'b1;
		tick(13);
		flt[5] = 1'b0;
		tick(8);
		chk("bias four cycles", 0, drv.fault);
	endtask
	task automatic run_fault(input int b);
		flt[b] = 1'b1;
		wait_bit(FLT, 1'b1, 40);
		chk("halted", 0, drv.switching_en);
		tick(b == 3 || b == 0 ? 260 : 180);
		chk("fault held", 1, drv.fault);
		flt[b] = 1'b0;
		wait_bit(FLT, 1'b0, 40);
		wait_bit(TST, 1'b1, 80);
		wait_bit(SW, 1'b1, 400);
	endtask
	task automatic run_unplug();
		int n;
		line_on = 1'b0;
		wait_bit(DIS, 1'b1, 800);
		chk("ac disconnect", 1, drv.ac_disconnect);
		for (n = 0; n < 400 && drv.line_cap_discharge_current_en === 1'b1; n++)
			tick(1);
		chk("discharge length", 150, n);
		line_on = 1'b1;
		wait_bit(ACD, 1'b0, 100);
	endtask
	initial begin
		tick(2);
		resetn_i = 1'b1;
		run_start();
		run_boot();
		run_bias_short();
		for (int k = 0; k < 5; k++)
			run_fault(fl[k]);
		run_unplug();
		end_of_test();
	end
endmodule
